// File: verif/ddr_mem_model.sv
// Behavioural DDR memory at the pin: makes the I/O clock, drives read data.
// Assumes the bench calls frame() on a system clock falling edge.
`timescale 1ns/1ps
`default_nettype none
module ddr_mem_model (
    output logic io_clk_out,
    output logic pin_drive_out,
    input wire logic pin_level_in,
    input wire logic pin_oe_in
);
    // ========================================
    // Pin seen per cycle: hi oe, hi data, lo oe, lo data
    logic [3:0] seen;
    event got;

    initial begin
        io_clk_out = 1'b0;
        pin_drive_out = 1'b0;
        seen = 4'h0;
    end

    // ========================================
    // One clock cycle per 183 ns call, 80 ns high; clock stands low between calls
    task automatic frame(input logic rise_bit, input logic fall_bit);
        #3;
        pin_drive_out = rise_bit;
        #40;
        io_clk_out = 1'b1;
        #40;
        pin_drive_out = fall_bit;
        #20;
        seen[3:2] = {pin_oe_in, pin_level_in};
        #20;
        io_clk_out = 1'b0;
        #40;
        pin_drive_out = ~fall_bit;
        #20;
        seen[1:0] = {pin_oe_in, pin_level_in};
        -> got;
    endtask : frame
endmodule : ddr_mem_model
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the DDR pin cell with a memory model on the pin.
// Assumes default parameters: one data bit, power-up level low.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ========================================
    // Stimulus and observed signals
    logic clk_sys_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [1:0] mode = ddr_io_pkg::MODE_INPUT;
    logic act_low = 1'b0, al_fall = 1'b0, use_strb = 1'b0;
    logic [3:0] bank = 4'h0;
    logic [7:0] inv = 8'h00;
    logic aclr = 1'b0, sclr = 1'b0, ce_in = 1'b1, ce_out = 1'b1, oe = 1'b0;
    logic fa = 1'b0, fb = 1'b0;
    logic strb_on = 1'b0;
    logic io_clk, drv, pin_w;
    logic cap_a, cap_b, cap_v, pdo, poe, strb_act;
    int n_fail = 0;
    int num_checks = 0;
    logic [1:0] cq[$];
    logic [3:0] oq[$];
    logic [1:0] prev_pair = 2'h0;
    logic ha = 1'b0, hb = 1'b0, hoe = 1'b0, prev_oe = 1'b0;

    always #4 clk_sys_in = ~clk_sys_in;
    assign pin_w = poe ? pdo : drv;

    ddr_io_element dut_u (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .mode_in(mode),
        .oe_active_low_in(act_low), .align_fall_in(al_fall),
        .use_strobe_in(use_strb), .bank_in(bank), .invert_in(inv),
        .io_in_clk_in(io_clk), .io_out_clk_in(io_clk), .strobe_in(strb_on & io_clk),
        .pin_data_in(pin_w), .async_clear_or_preset_in(aclr),
        .sync_reset_in(sclr), .ce_in_in(ce_in), .register_clock_enable_in(ce_out),
        .oe_in(oe), .fab_data_a_in(fa), .fab_data_b_in(fb),
        .cap_a_out(cap_a), .cap_b_out(cap_b), .cap_valid_out(cap_v),
        .pin_data_out(pdo), .pin_oe_out(poe), .strobe_active_out(strb_act)
    );

    ddr_mem_model mem_u (
        .io_clk_out(io_clk), .pin_drive_out(drv),
        .pin_level_in(pin_w), .pin_oe_in(poe)
    );

    // ========================================
    // Comparison and verdict
    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wrap_up();
        if (cq.size() != 0 || oq.size() != 0) begin
            n_fail++;
            $display("Error pending results expected 0 seen %0d", cq.size() + oq.size());
        end
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up

    // ========================================
    // Result watchers
    always @(negedge clk_sys_in) begin
        if (cap_v === 1'b1) begin
            if (cq.size() == 0) check("capture", 4'hF, {2'h0, cap_a, cap_b});
            else check("capture", {2'h0, cq.pop_front()}, {2'h0, cap_a, cap_b});
        end
    end

    always @(mem_u.got) begin
        if (oq.size() != 0) check("pin", oq.pop_front(), mem_u.seen);
    end

    // ========================================
    // One input cycle with random read pair
    task automatic in_cyc(input logic ce, input logic ice);
        logic [1:0] p;
        @(negedge clk_sys_in);
        p = 2'($urandom);
        ce_in = ce;
        inv[ddr_io_pkg::INV_CE_IN] = ice;
        if (ce ^ ice) begin
            cq.push_back(al_fall ? p : prev_pair);
            prev_pair = p;
        end
        mem_u.frame(p[1], p[0]);
    endtask : in_cyc

    // ========================================
    // One output cycle with random fabric pair
    task automatic out_cyc(input logic en, input logic ien, input logic sr, input logic o);
        logic [1:0] d;
        logic hio;
        @(negedge clk_sys_in);
        d = 2'($urandom);
        {fa, fb} = d;
        ce_out = en;
        inv[ddr_io_pkg::INV_CE_OUT] = ien;
        sclr = sr;
        oe = o;
        prev_oe = hoe;
        if (en ^ ien) begin
            {ha, hb, hoe} = sr ? 3'h0 : {d, o ^ act_low};
        end
        hio = (mode == ddr_io_pkg::MODE_BIDIR) ? (prev_oe & hoe) : hoe;
        oq.push_back({hio, hio ? ha : 1'b0, hoe, hoe ? hb : 1'b1});
        mem_u.frame(1'b0, 1'b0);
    endtask : out_cyc

    // ========================================
    // Main sequence
    initial begin
        void'($urandom(32'hB854));
        repeat (8) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        nrst_in = 1'b1;
        use_strb = 1'b1;
        for (int b = 0; b < 16; b++) begin
            @(negedge clk_sys_in);
            bank = 4'(b);
            repeat (3) @(negedge clk_sys_in);
            check("strobe", {3'h0, b == 3 || b == 4 || b == 7 || b == 8}, {3'h0, strb_act});
        end
        @(negedge clk_sys_in);
        bank = 4'h1;
        repeat (3) in_cyc(1'b1, 1'b0);
        @(negedge clk_sys_in);
        al_fall = 1'b1;
        repeat (3) in_cyc(1'b1, 1'b0);
        in_cyc(1'b0, 1'b0);
        in_cyc(1'b0, 1'b1);
        in_cyc(1'b1, 1'b0);
        @(negedge clk_sys_in);
        bank = 4'h3;
        in_cyc(1'b1, 1'b0);
        check("strobe hold", 4'h1, 4'(cq.size()));
        void'(cq.pop_back());
        @(negedge clk_sys_in);
        strb_on = 1'b1;
        in_cyc(1'b1, 1'b0);
        @(negedge clk_sys_in);
        ce_in = 1'b0;
        mode = ddr_io_pkg::MODE_BIDIR;
        out_cyc(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (2) out_cyc(1'b1, 1'b0, 1'b0, 1'b1);
        @(negedge clk_sys_in);
        mode = ddr_io_pkg::MODE_OUTPUT;
        repeat (4) out_cyc(1'b1, 1'b0, 1'b0, 1'b1);
        repeat (2) out_cyc(1'b0, 1'b0, 1'b0, 1'b1);
        out_cyc(1'b0, 1'b1, 1'b0, 1'b1);
        out_cyc(1'b1, 1'b0, 1'b1, 1'b1);
        @(negedge clk_sys_in);
        act_low = 1'b1;
        out_cyc(1'b1, 1'b0, 1'b0, 1'b0);
        @(negedge clk_sys_in);
        aclr = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        check("clear", 4'h0, {2'h0, pdo, poe});
        aclr = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        wrap_up();
    end

    initial begin
        #100000;
        n_fail++;
        wrap_up();
    end
endmodule : testbench
`default_nettype wire

// File: verilog/ddr_io_element.sv
// DDR pin I/O cell: two-edge input capture, clock-muxed DDR output, bidir OE.
// Assumes I/O clocks, strobe, pin and clear come from outside; fabric is local.
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Two input registers capture alternating edges
// R2: Latch aligns both bits to one edge
// R3: Rising edge loads two output registers
// R4: Clock level selects first or second bit
// R5: Bidir mode combines input and output paths
// R6: Falling-edge OE register delays driver turn-on
// R7: Output enable polarity high, optionally low
// R8: Output clock enable high loads registers
// R9: Output clock enable low holds registers
// R10: Every cell input individually invertible; the cell does not invert pin or fabric data
// R11: Strobe capture only in banks 3,4,7,8
// R12: Other banks ignore strobe, use I/O clock
// R13: Up to 200 MHz, 400 Mbps per pin
// R14: Shared clear/preset, programmable power-up level
// R15: Registers also accept synchronous reset
// R16: Output/OE share clock; input separate
// R17: Held outputs keep alternating last pair
module ddr_io_element #(
    parameter int DATA_W = 1,
    parameter bit POWER_UP_HIGH = 1'b0
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [1:0] mode_in,
    input wire logic oe_active_low_in,
    input wire logic align_fall_in,
    input wire logic use_strobe_in,
    input wire logic [3:0] bank_in,
    input wire logic [ddr_io_pkg::INV_W-1:0] invert_in,
    input wire logic io_in_clk_in,
    input wire logic io_out_clk_in,
    input wire logic strobe_in,
    input wire logic [DATA_W-1:0] pin_data_in,
    input wire logic async_clear_or_preset_in,
    input wire logic sync_reset_in,
    input wire logic ce_in_in,
    input wire logic register_clock_enable_in,
    input wire logic oe_in,
    input wire logic [DATA_W-1:0] fab_data_a_in,
    input wire logic [DATA_W-1:0] fab_data_b_in,
    output logic [DATA_W-1:0] cap_a_out,
    output logic [DATA_W-1:0] cap_b_out,
    output logic cap_valid_out,
    output logic [DATA_W-1:0] pin_data_out,
    output logic [DATA_W-1:0] pin_oe_out,
    output logic strobe_active_out
);
    localparam logic [DATA_W-1:0] PU = {DATA_W{POWER_UP_HIGH}};

    initial begin
        if (DATA_W < 1) $error("ddr_io_element: DATA_W must be at least 1");
        if (ddr_io_pkg::MAX_PIN_RATE_MBPS != 2 * ddr_io_pkg::MAX_MEM_CLK_MHZ)
            $error("ddr_io_element: pin rate must be twice memory clock"); // R13
    end

    function automatic logic bank_has_shift(input logic [3:0] bank);
        bank_has_shift = (bank == ddr_io_pkg::BANK_TOP_A) || (bank == ddr_io_pkg::BANK_TOP_B) ||
            (bank == ddr_io_pkg::BANK_BOT_A) || (bank == ddr_io_pkg::BANK_BOT_B);
    endfunction : bank_has_shift

    // ========================================
    // Outside signals: sync and inversion
    logic [3:0] lv_sync;
    logic [DATA_W-1:0] pin_s;
    logic in_clk_s;
    logic out_clk_s;
    logic strobe_s;
    logic aclr_s;

    io_level_sync #(.W(4)) u_ctl_sync (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .invert_in({invert_in[ddr_io_pkg::INV_ACLR], invert_in[ddr_io_pkg::INV_STROBE],
            invert_in[ddr_io_pkg::INV_OUT_CLK], invert_in[ddr_io_pkg::INV_IN_CLK]}), // R10
        .async_in({async_clear_or_preset_in, strobe_in, io_out_clk_in, io_in_clk_in}),
        .sync_out(lv_sync)
    );

    io_level_sync #(.W(DATA_W)) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .invert_in('0),
        .async_in(pin_data_in),
        .sync_out(pin_s)
    );

    assign in_clk_s = lv_sync[0];
    assign out_clk_s = lv_sync[1];
    assign strobe_s = lv_sync[2];
    assign aclr_s = lv_sync[3];

    // Fabric-side inversion
    logic ce_in_x;
    logic ce_out_x;
    logic sclr_x;
    logic oe_x;
    assign ce_in_x = ce_in_in ^ invert_in[ddr_io_pkg::INV_CE_IN]; // R10
    assign ce_out_x = register_clock_enable_in ^ invert_in[ddr_io_pkg::INV_CE_OUT]; // R10
    assign sclr_x = sync_reset_in ^ invert_in[ddr_io_pkg::INV_SCLR]; // R10
    assign oe_x = oe_in ^ invert_in[ddr_io_pkg::INV_OE] ^ oe_active_low_in; // R7

    // ========================================
    // Capture clock selection and edges
    logic strobe_ok;
    logic cap_clk;
    logic cap_prev;
    logic out_prev;
    logic cap_rise;
    logic cap_fall;
    logic out_rise;
    logic out_fall;
    logic in_on;
    logic out_on;

    assign strobe_ok = use_strobe_in && bank_has_shift(bank_in); // R11
    assign cap_clk = strobe_ok ? strobe_s : in_clk_s; // R12
    assign cap_rise = cap_clk && !cap_prev;
    assign cap_fall = !cap_clk && cap_prev;
    assign out_rise = out_clk_s && !out_prev;
    assign out_fall = !out_clk_s && out_prev;
    assign in_on = (mode_in == ddr_io_pkg::MODE_INPUT) || (mode_in == ddr_io_pkg::MODE_BIDIR); // R5
    assign out_on = (mode_in == ddr_io_pkg::MODE_OUTPUT) || (mode_in == ddr_io_pkg::MODE_BIDIR); // R5

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cap_prev <= 1'b0;
            out_prev <= 1'b0;
        end else begin
            cap_prev <= cap_clk;
            out_prev <= out_clk_s;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            strobe_active_out <= 1'b0;
        end else begin
            strobe_active_out <= strobe_ok; // R12
        end
    end

    // ========================================
    // Input path
    logic [DATA_W-1:0] reg_rise;
    logic [DATA_W-1:0] reg_fall;
    logic [DATA_W-1:0] latch_hi;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rise <= PU;
            reg_fall <= PU;
            latch_hi <= PU;
        end else if (aclr_s) begin
            reg_rise <= PU; // R14
            reg_fall <= PU;
            latch_hi <= PU;
        end else if (in_on && ce_in_x && (cap_rise || cap_fall)) begin
            if (sclr_x) begin
                reg_rise <= PU; // R15
                reg_fall <= PU;
                latch_hi <= PU;
            end else if (cap_rise) begin
                reg_rise <= pin_s; // R1
            end else begin
                reg_fall <= pin_s; // R1
                latch_hi <= reg_rise; // R2
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cap_a_out <= PU;
            cap_b_out <= PU;
            cap_valid_out <= 1'b0;
        end else if (aclr_s) begin
            cap_a_out <= PU; // R14
            cap_b_out <= PU;
            cap_valid_out <= 1'b0;
        end else if (in_on && ce_in_x && !sclr_x && !align_fall_in && cap_rise) begin
            cap_a_out <= latch_hi; // R2
            cap_b_out <= reg_fall;
            cap_valid_out <= 1'b1;
        end else if (in_on && ce_in_x && !sclr_x && align_fall_in && cap_fall) begin
            cap_a_out <= reg_rise; // R2
            cap_b_out <= pin_s;
            cap_valid_out <= 1'b1;
        end else begin
            cap_valid_out <= 1'b0;
        end
    end

    // ========================================
    // Output and OE registers, one clock
    logic [DATA_W-1:0] reg_a;
    logic [DATA_W-1:0] reg_b;
    logic [DATA_W-1:0] oe_reg;
    logic [DATA_W-1:0] oe_neg;
    logic [DATA_W-1:0] next_drive;

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_a <= PU;
            reg_b <= PU;
            oe_reg <= PU;
        end else if (aclr_s) begin
            reg_a <= PU; // R14
            reg_b <= PU;
            oe_reg <= PU;
        end else if (out_rise && ce_out_x) begin // R16
            if (sclr_x) begin
                reg_a <= PU; // R15
                reg_b <= PU;
                oe_reg <= PU;
            end else begin
                reg_a <= fab_data_a_in; // R3
                reg_b <= fab_data_b_in; // R8
                oe_reg <= {DATA_W{oe_x}}; // R7
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            oe_neg <= PU;
        end else if (aclr_s) begin
            oe_neg <= PU; // R14
        end else if (out_fall && ce_out_x) begin
            oe_neg <= sclr_x ? PU : oe_reg; // R6
        end
    end

    always_comb begin
        if (mode_in == ddr_io_pkg::MODE_BIDIR) begin
            next_drive = oe_reg & oe_neg; // R6
        end else if (mode_in == ddr_io_pkg::MODE_OUTPUT) begin
            next_drive = oe_reg;
        end else begin
            next_drive = '0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_data_out <= PU;
            pin_oe_out <= '0;
        end else begin
            pin_data_out <= out_clk_s ? reg_a : reg_b; // R4 R17
            pin_oe_out <= out_on ? next_drive : '0;
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    sequence s_cap_rise_taken;
        in_on && ce_in_x && !sclr_x && !aclr_s && cap_rise;
    endsequence

    sequence s_out_load;
        out_rise && ce_out_x && !sclr_x && !aclr_s;
    endsequence

    property p_rise_capture;
        s_cap_rise_taken |=> reg_rise == $past(pin_s);
    endproperty
    a_rise_capture: assert property (p_rise_capture) else $error("rise capture missed"); // R1

    property p_aligned_pair;
        s_cap_rise_taken and (!align_fall_in) |=> cap_valid_out && cap_b_out == $past(reg_fall);
    endproperty
    a_aligned_pair: assert property (p_aligned_pair) else $error("pair not aligned"); // R2

    property p_out_load;
        s_out_load |=> reg_a == $past(fab_data_a_in) && reg_b == $past(fab_data_b_in);
    endproperty
    a_out_load: assert property (p_out_load) else $error("output regs not loaded"); // R3

    property p_level_mux;
        out_clk_s |=> pin_data_out == $past(reg_a);
    endproperty
    a_level_mux: assert property (p_level_mux) else $error("high phase bit wrong"); // R4

    property p_oe_delay;
        (mode_in == ddr_io_pkg::MODE_BIDIR) && (oe_neg == '0) |=> pin_oe_out == '0;
    endproperty
    a_oe_delay: assert property (p_oe_delay) else $error("driver on before falling edge"); // R6

    property p_oe_polarity;
        s_out_load |=> oe_reg == {DATA_W{$past(oe_x)}};
    endproperty
    a_oe_polarity: assert property (p_oe_polarity) else $error("oe polarity wrong"); // R7

    property p_hold;
        out_rise && !ce_out_x && !aclr_s |=> $stable(reg_a) && $stable(reg_b);
    endproperty
    a_hold: assert property (p_hold) else $error("held regs changed"); // R9

    property p_strobe_ignored;
        !(use_strobe_in && bank_has_shift(bank_in)) |=> !strobe_active_out;
    endproperty
    a_strobe_ignored: assert property (p_strobe_ignored) else $error("strobe used off-bank"); // R12

    property p_clear;
        aclr_s |=> reg_a == PU && reg_rise == PU && oe_neg == PU;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not set power-up level"); // R14

    property p_sync_reset;
        out_rise && ce_out_x && sclr_x && !aclr_s |=> reg_b == PU && oe_reg == PU;
    endproperty
    a_sync_reset: assert property (p_sync_reset) else $error("sync reset ignored"); // R15
endmodule : ddr_io_element
`default_nettype wire

// File: verilog/ddr_io_pkg.sv
// Constants shared by the DDR pin cell and its testbench.
// Assumes one 125 MHz system clock that samples every I/O clock.
package ddr_io_pkg;
    // ========================================
    // Clocking and rates
    localparam int SYS_CLK_MHZ = 125;
    localparam int MAX_MEM_CLK_MHZ = 200;
    localparam int MAX_PIN_RATE_MBPS = 400;
    localparam int SYNC_STAGES = 2;

    // ========================================
    // Cell modes
    localparam logic [1:0] MODE_INPUT = 2'h0;
    localparam logic [1:0] MODE_OUTPUT = 2'h1;
    localparam logic [1:0] MODE_BIDIR = 2'h2;

    // ========================================
    // Inversion mask bit positions
    localparam int INV_IN_CLK = 0;
    localparam int INV_OUT_CLK = 1;
    localparam int INV_CE_IN = 2;
    localparam int INV_CE_OUT = 3;
    localparam int INV_ACLR = 4;
    localparam int INV_SCLR = 5;
    localparam int INV_OE = 6;
    localparam int INV_STROBE = 7;
    localparam int INV_W = 8;

    // ========================================
    // Banks with strobe phase shift
    localparam logic [3:0] BANK_TOP_A = 4'h3;
    localparam logic [3:0] BANK_TOP_B = 4'h4;
    localparam logic [3:0] BANK_BOT_A = 4'h7;
    localparam logic [3:0] BANK_BOT_B = 4'h8;
endpackage : ddr_io_pkg

// File: verilog/io_level_sync.sv
// Inverts and double-flops levels arriving from outside the clock domain.
// Assumes invert controls are static configuration.
`timescale 1ns/1ps
`default_nettype none
module io_level_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [W-1:0] invert_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;

    initial begin
        if (W < 1) $error("io_level_sync: W must be at least 1");
    end

    // ========================================
    // Two-stage synchroniser
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1 ^ invert_in;
        end
    end
endmodule : io_level_sync
`default_nettype wire
